// ===== slot_timer_regs.svh
// Operation
// - count steps down once per active edge
// - reaching zero sets the expiry flag
// - stop mode halts the count at zero
// - free-run mode wraps zero to all ones
// - expiry with local enable sets irq flag
// - request needs local and global enable
// - count write loads value immediately
// - write on active edge stores value minus one
// - 18-bit prescaler, top eight bits from register
// - prescaler counts up, wraps at the terminal value
// - all events aligned to system tick
// - interval is value times multiplier per tick
// - expiry pulses the dma trigger
// - deep sleep exit restores reset values
// - writing one to expiry flag does nothing
// - stop mode: generator runs while count nonzero
// - free-run mode: generator always runs
// - prescale value zero means 256
`ifndef SLOT_TIMER_REGS_SVH
`define SLOT_TIMER_REGS_SVH

// ==========================================================
// register offsets in special function space
`define SLOT_COUNT_ADDR 8'h9c
`define SLOT_PRESCALE_ADDR 8'h9d
`define SLOT_CONTROL_ADDR 8'h9e

// ==========================================================
// control field positions
`define CTL_EXPIRY_BIT 6
`define CTL_IRQ_EN_BIT 4
`define CTL_FREE_RUN_BIT 2
`define CTL_MULT_LSB 0

// ==========================================================
// reset values
`define SLOT_COUNT_RESET 8'h00
`define SLOT_PRESCALE_RESET 8'h00
`define SLOT_CONTROL_RESET 8'h00

// ==========================================================
// prescaler step per tick for each multiplier code
`define STEP_MULT_64 11'h010
`define STEP_MULT_128 11'h008
`define STEP_MULT_256 11'h004
`define STEP_MULT_1024 11'h001
`define PRESCALE_LOW_BITS 10

`endif

// ===== mac_slot_pkg.sv
package mac_slot_pkg;

  // interval multiplier selection
  typedef enum logic [1:0] {
    MULT_64 = 2'b00,
    MULT_128 = 2'b01,
    MULT_256 = 2'b10,
    MULT_1024 = 2'b11
  } interval_multiplier_t;

  // control register layout
  typedef struct packed {
    logic reservedHigh;
    logic expiryFlag;
    logic reservedMid;
    logic irqEnable;
    logic reservedLow;
    logic freeRunSelect;
    interval_multiplier_t intervalMultiplier;
  } slot_ctrl_t;

  // one special function register write
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } sfr_write_t;

  // tick generator state
  typedef enum logic {
    GEN_IDLE = 1'b0,
    GEN_RUN = 1'b1
  } gen_state_t;

endpackage : mac_slot_pkg

// ===== mac_slot_down_timer.sv
`timescale 1ns/100ps
`include "slot_timer_regs.svh"

module mac_slot_down_timer #(
  parameter int PRESCALE_WIDTH = 18 // prescaler counter width
) (
  input wire logic clock, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic clockEnable, // freezes state when low; event pulse outputs clear to zero
  input wire logic systemTickRate, // tick strobe from clock control
  input wire logic deepSleepExit, // pulse on return from deepest sleep
  input wire mac_slot_pkg::sfr_write_t sfrWrite, // register write port
  input wire logic [7:0] sfrReadAddr, // register read address
  output logic [7:0] sfrReadData, // registered read data
  input wire logic slotIrqGlobalEnable, // global enable bit for this timer
  output logic slotIrqFlag, // pulse that sets the interrupt flag
  output logic slotIrqRequest, // pulse requesting an interrupt
  output logic slotExpiryDmaTrigger // pulse to the dma controller
);
  import mac_slot_pkg::*;

  // ==========================================================
  // state
  logic [7:0] countValue;
  logic [7:0] prescaleValue;
  slot_ctrl_t control;
  logic [PRESCALE_WIDTH-1:0] prescaler;
  gen_state_t genState;

  // ==========================================================
  // decoded write strobes
  logic countWrite;
  logic prescaleWrite;
  logic controlWrite;
  slot_ctrl_t writeCtrl;

  assign countWrite = sfrWrite.en && (sfrWrite.addr == `SLOT_COUNT_ADDR);
  assign prescaleWrite = sfrWrite.en && (sfrWrite.addr == `SLOT_PRESCALE_ADDR);
  assign controlWrite = sfrWrite.en && (sfrWrite.addr == `SLOT_CONTROL_ADDR);
  assign writeCtrl = slot_ctrl_t'(sfrWrite.data);

  // ==========================================================
  // prescaler terminal value
  logic [10:0] stepSize;
  logic [PRESCALE_WIDTH:0] fullSpan;
  logic [PRESCALE_WIDTH:0] terminal;

  // step per tick scales a fixed 1024 span down to the multiplier
  always_comb begin
    unique case (control.intervalMultiplier)
      MULT_64: stepSize = `STEP_MULT_64;
      MULT_128: stepSize = `STEP_MULT_128;
      MULT_256: stepSize = `STEP_MULT_256;
      MULT_1024: stepSize = `STEP_MULT_1024;
    endcase
  end

  // zero in the value register stands for 256, one bit above the field
  always_comb begin
    fullSpan = '0;
    fullSpan[PRESCALE_WIDTH] = (prescaleValue == 8'h00);
    fullSpan[PRESCALE_WIDTH-1 -: 8] = prescaleValue;
  end

  // last value before the wrap, so the span is value times multiplier ticks
  assign terminal = fullSpan - (PRESCALE_WIDTH+1)'(stepSize);

  // ==========================================================
  // tick generator run condition
  logic wantRun;
  logic activeEdge;

  // free-run keeps going; stop mode only while count is nonzero
  assign wantRun = control.freeRunSelect || (countValue != 8'h00);

  // one active edge when the prescaler sits exactly on terminal at a system tick
  assign activeEdge = (genState == GEN_RUN) && systemTickRate &&
    (prescaler == terminal[PRESCALE_WIDTH-1:0]);

  // generator state
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      genState <= GEN_IDLE;
    end else if (clockEnable) begin
      if (deepSleepExit) begin
        genState <= GEN_IDLE;
      end else begin
        unique case (genState)
          GEN_IDLE: if (wantRun) genState <= GEN_RUN;
          GEN_RUN: if (!wantRun) genState <= GEN_IDLE;
        endcase
      end
    end
  end

  // prescaler counts up by its step; held at zero while idle so it restarts clean
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prescaler <= '0;
    end else if (clockEnable) begin
      if (deepSleepExit || (genState == GEN_IDLE) || !wantRun) begin
        prescaler <= '0;
      end else if (systemTickRate) begin
        if (prescaler >= terminal[PRESCALE_WIDTH-1:0]) begin
          // a shortened value can leave it past the end; wrap there too
          prescaler <= '0;
        end else begin
          prescaler <= prescaler + PRESCALE_WIDTH'(stepSize);
        end
      end
    end
  end

  // ==========================================================
  // count register
  logic [7:0] next_count;
  logic decremented;
  logic expiryEvent;

  // a write wins the load but still takes the coincident edge
  always_comb begin
    next_count = countValue;
    decremented = 1'b0;
    if (countWrite && activeEdge) begin
      next_count = sfrWrite.data - 8'h01;
      decremented = 1'b1;
    end else if (countWrite) begin
      next_count = sfrWrite.data;
    end else if (activeEdge) begin
      // from zero only free-run gets here, giving 0xff
      next_count = countValue - 8'h01;
      decremented = 1'b1;
    end
  end

  // stop mode never sees an edge at zero, so it stays there
  assign expiryEvent = decremented && (next_count == 8'h00);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      countValue <= `SLOT_COUNT_RESET;
    end else if (clockEnable) begin
      if (deepSleepExit) begin
        countValue <= `SLOT_COUNT_RESET;
      end else begin
        countValue <= next_count;
      end
    end
  end

  // ==========================================================
  // prescale value register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prescaleValue <= `SLOT_PRESCALE_RESET;
    end else if (clockEnable) begin
      if (deepSleepExit) begin
        prescaleValue <= `SLOT_PRESCALE_RESET;
      end else if (prescaleWrite) begin
        prescaleValue <= sfrWrite.data;
      end
    end
  end

  // ==========================================================
  // control register in one process so the struct has a single driver;
  // reserved bits are never written after reset, so they read zero
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      control <= slot_ctrl_t'(`SLOT_CONTROL_RESET);
    end else if (clockEnable) begin
      if (deepSleepExit) begin
        control <= slot_ctrl_t'(`SLOT_CONTROL_RESET);
      end else begin
        if (controlWrite) begin
          control.irqEnable <= writeCtrl.irqEnable;
          control.freeRunSelect <= writeCtrl.freeRunSelect;
          control.intervalMultiplier <= writeCtrl.intervalMultiplier;
        end
        // hardware set beats a software clear in the same cycle
        if (expiryEvent) begin
          control.expiryFlag <= 1'b1;
        end else if (controlWrite && !writeCtrl.expiryFlag) begin
          control.expiryFlag <= 1'b0;
        end
        // writing one leaves the bit as it is
      end
    end
  end

  // ==========================================================
  // event outputs, registered on the same edge that sets the flag
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      slotIrqFlag <= 1'b0;
      slotIrqRequest <= 1'b0;
      slotExpiryDmaTrigger <= 1'b0;
    end else if (clockEnable) begin
      slotIrqFlag <= expiryEvent && control.irqEnable;
      slotIrqRequest <= expiryEvent && control.irqEnable &&
        slotIrqGlobalEnable;
      slotExpiryDmaTrigger <= expiryEvent;
    end else begin
      // pulses must not stretch while frozen
      slotIrqFlag <= 1'b0;
      slotIrqRequest <= 1'b0;
      slotExpiryDmaTrigger <= 1'b0;
    end
  end

  // ==========================================================
  // read port, one cycle latency; unmapped addresses read zero
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sfrReadData <= 8'h00;
    end else if (clockEnable) begin
      unique case (sfrReadAddr)
        `SLOT_COUNT_ADDR: sfrReadData <= countValue;
        `SLOT_PRESCALE_ADDR: sfrReadData <= prescaleValue;
        `SLOT_CONTROL_ADDR: sfrReadData <= control;
        default: sfrReadData <= 8'h00;
      endcase
    end
  end

endmodule : mac_slot_down_timer

// ===== mac_slot_checker.sv
`timescale 1ns/100ps
module mac_slot_checker (
  input wire logic clock, // system clock
  input wire logic sys_rst, // async reset
  input wire logic clockEnable, // run enable
  input wire logic systemTickRate, // tick strobe
  input wire logic deepSleepExit, // sleep restore
  input wire mac_slot_pkg::sfr_write_t sfrWrite, // write port
  input wire logic [7:0] sfrReadAddr, // read address
  input wire logic [7:0] sfrReadData, // read data
  input wire logic slotIrqGlobalEnable, // global enable
  input wire logic slotIrqFlag, // irq flag pulse
  input wire logic slotIrqRequest, // irq request pulse
  input wire logic slotExpiryDmaTrigger // dma pulse
);
  import mac_slot_pkg::*;
  // ==========================================================
  // timing relations at the ports
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // request follows the flag gated by the global enable
  irq_request_gate_a: assert property (slotIrqFlag && $stable(slotIrqGlobalEnable)
    |-> slotIrqRequest == slotIrqGlobalEnable)
    else $error("irq request gate wrong");
  flag_with_dma_a: assert property (slotIrqFlag |-> slotExpiryDmaTrigger)
    else $error("irq flag without dma pulse");
  dma_single_pulse_a: assert property (slotExpiryDmaTrigger |=> !slotExpiryDmaTrigger)
    else $error("dma pulse too long");
  // the pulse is registered from the tick cycle, so the tick is one edge back
  expiry_tick_aligned_a: assert property (slotExpiryDmaTrigger |-> $past(systemTickRate, 1))
    else $error("expiry not on a tick");
  // a write with no tick must read back untouched
  count_write_loads_a: assert property (clockEnable && sfrWrite.en && sfrWrite.addr == 8'h9c
    && !systemTickRate ##1 clockEnable && sfrReadAddr == 8'h9c
    |=> sfrReadData == $past(sfrWrite.data, 2))
    else $error("count write not loaded");
  reserved_reads_zero_a: assert property ($past(clockEnable) && $past(sfrReadAddr) == 8'h9e
    |-> !(sfrReadData[7] | sfrReadData[5] | sfrReadData[3]))
    else $error("reserved control bits set");
  sleep_clears_count_a: assert property (deepSleepExit && clockEnable && !sfrWrite.en
    ##1 clockEnable && sfrReadAddr == 8'h9c |=> sfrReadData == 8'h00)
    else $error("count kept over deep sleep");
  // flag sets with the event edge, so the read launched one edge later shows it
  expiry_bit_shown_a: assert property (slotExpiryDmaTrigger && clockEnable
    && sfrReadAddr == 8'h9e |=> sfrReadData[6])
    else $error("expiry bit not set");
  // main scenarios
  cover property (slotIrqRequest);
  cover property (slotIrqFlag && !slotIrqRequest);
  cover property (deepSleepExit);
endmodule : mac_slot_checker

bind mac_slot_down_timer mac_slot_checker chk (.clock(clock), .sys_rst(sys_rst),
  .clockEnable(clockEnable), .systemTickRate(systemTickRate), .deepSleepExit(deepSleepExit),
  .sfrWrite(sfrWrite), .sfrReadAddr(sfrReadAddr), .sfrReadData(sfrReadData),
  .slotIrqGlobalEnable(slotIrqGlobalEnable), .slotIrqFlag(slotIrqFlag),
  .slotIrqRequest(slotIrqRequest), .slotExpiryDmaTrigger(slotExpiryDmaTrigger));

// ===== tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import mac_slot_pkg::*;
  logic clock, sys_rst, clockEnable, systemTickRate, deepSleepExit, slotIrqGlobalEnable;
  sfr_write_t sfrWrite;
  logic [7:0] sfrReadAddr, sfrReadData;
  logic slotIrqFlag, slotIrqRequest, slotExpiryDmaTrigger;
  int num_errors, checks_done, n;
  // rows: address, written value, read-back value
  logic [7:0] rows [6][3] = '{'{8'h9c, 8'h5a, 8'h5a}, '{8'h9d, 8'h09, 8'h09},
    '{8'h9e, 8'h57, 8'h17}, '{8'h9f, 8'haa, 8'h00}, '{8'h9b, 8'h11, 8'h00},
    '{8'h9e, 8'h00, 8'h00}};
  int mults [4] = '{64, 128, 256, 1024};
  mac_slot_down_timer uut (.clock(clock), .sys_rst(sys_rst), .clockEnable(clockEnable),
    .systemTickRate(systemTickRate), .deepSleepExit(deepSleepExit), .sfrWrite(sfrWrite),
    .sfrReadAddr(sfrReadAddr), .sfrReadData(sfrReadData),
    .slotIrqGlobalEnable(slotIrqGlobalEnable), .slotIrqFlag(slotIrqFlag),
    .slotIrqRequest(slotIrqRequest), .slotExpiryDmaTrigger(slotExpiryDmaTrigger));
  // ==========================================================
  // clock and helpers
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task test_done;
    $display("errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one write, then an idle cycle so the strobe never toggles twice in a step
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfrWrite = '{1'b1, a, d};
    sfrReadAddr = a;
    @(posedge clock);
    #1 sfrWrite.en = 1'b0;
    @(posedge clock);
    #1;
  endtask : wr
  // read data is registered, so it lands one edge after the address; the task waits two
  task rd(input logic [7:0] a, input logic [7:0] e);
    sfrReadAddr = a;
    repeat (2) @(posedge clock);
    #1 chk(sfrReadData, e);
  endtask : rd
  // load with ticks held off, then tick every cycle and time the expiry
  task run(input logic [7:0] ctl, input logic [7:0] pre, input logic [7:0] cnt,
           input logic gEn, input int exp);
    systemTickRate = 1'b0;
    wr(8'h9d, pre);
    wr(8'h9e, ctl);
    wr(8'h9c, cnt);
    slotIrqGlobalEnable = gEn;
    sfrReadAddr = 8'h9e;
    systemTickRate = 1'b1;
    n = 0;
    while (slotExpiryDmaTrigger !== 1'b1 && n < 20000) begin
      @(posedge clock);
      #1 n++;
    end
    chk(8'(n >= exp && n <= exp + 3), 8'h01);
    chk(8'(slotIrqFlag), 8'(ctl[4]));
    chk(8'(slotIrqRequest), 8'(ctl[4] & gEn));
  endtask : run
  // ==========================================================
  // watchdog, generous over the roughly 18.4k cycles of tests
  initial begin
    #200000;
    num_errors++;
    test_done();
  end
  // ==========================================================
  // main sequence
  initial begin
    {sys_rst, clockEnable, systemTickRate, deepSleepExit, slotIrqGlobalEnable} = 5'b11000;
    sfrWrite = '0;
    sfrReadAddr = 8'h00;
    repeat (16) @(posedge clock);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 3; i++) rd(8'h9c + 8'(i), 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(rows[i][0], rows[i][1]);
      rd(rows[i][0], rows[i][2]);
    end
    run(8'h10, 8'h01, 8'h02, 1'b1, 128);
    rd(8'h9e, 8'h50);
    repeat (200) @(posedge clock);
    #1 rd(8'h9c, 8'h00);
    wr(8'h9e, 8'h10);
    rd(8'h9e, 8'h10);
    wr(8'h9e, 8'h50);
    rd(8'h9e, 8'h10);
    for (int m = 0; m < 4; m++) run(8'h10 | 8'(m), 8'h01, 8'h01, 1'(m), mults[m]);
    run(8'h00, 8'h00, 8'h01, 1'b1, 16384);
    run(8'h04, 8'h01, 8'h01, 1'b1, 64);
    // count sits at zero for one more interval before it wraps
    repeat (64) @(posedge clock);
    #1 rd(8'h9c, 8'hff);
    // restore from deep sleep while the free-running count is nonzero
    deepSleepExit = 1'b1;
    @(posedge clock);
    #1 deepSleepExit = 1'b0;
    for (int i = 0; i < 3; i++) rd(8'h9c + 8'(i), 8'h00);
    test_done();
  end
endmodule : tb_top
